// >>> logic/vtg_map.svh
// Timing, field and reset constants for the 640x480 video timing generator
`ifndef VTG_MAP_SVH
`define VTG_MAP_SVH

// System clock and pixel clock rates in MHz
`define VTG_SYS_CLK_MHZ 125
`define VTG_PIX_CLK_MHZ 25
// System clocks per pixel clock
`define VTG_PIX_DIV (`VTG_SYS_CLK_MHZ / `VTG_PIX_CLK_MHZ)

// Horizontal line layout in pixel clocks
`define VTG_H_VISIBLE 640
`define VTG_H_FRONT 16
`define VTG_H_SYNC 96
`define VTG_H_BACK 48
`define VTG_H_TOTAL (`VTG_H_VISIBLE + `VTG_H_FRONT + `VTG_H_SYNC + `VTG_H_BACK)

// Vertical frame layout in lines
`define VTG_V_VISIBLE 480
`define VTG_V_FRONT 10
`define VTG_V_SYNC 2
`define VTG_V_BACK 29
`define VTG_V_TOTAL (`VTG_V_VISIBLE + `VTG_V_FRONT + `VTG_V_SYNC + `VTG_V_BACK)

// Counter and address widths
`define VTG_CNT_W 10
`define VTG_ADDR_ROW_W 9
`define VTG_ADDR_W (`VTG_ADDR_ROW_W + `VTG_CNT_W)

// Pixel word layout: red high, green middle, blue low
`define VTG_CHAN_W 4
`define VTG_PIX_W (3 * `VTG_CHAN_W)
`define VTG_RED_LSB 8
`define VTG_GREEN_LSB 4
`define VTG_BLUE_LSB 0

// Reset and idle values, and buffer depth
`define VTG_BLANK 12'h000
`define VTG_SYNC_IDLE 1'b1
`define VTG_BUF_DEPTH 2

`endif

// >>> logic/vtg_pkg.sv
// Types and shared helper functions for the video timing generator
package vtg_pkg;
  `include "vtg_map.svh"

  // One pixel, 4 bits per channel
  typedef logic [`VTG_PIX_W-1:0] vtg_pixel_t;
  // Column or row counter value
  typedef logic [`VTG_CNT_W-1:0] vtg_count_t;
  // Memory read address
  typedef logic [`VTG_ADDR_W-1:0] vtg_addr_t;

  // Position of a counter within its line or frame
  typedef enum logic [1:0] {
    VTG_VISIBLE,
    VTG_FRONT,
    VTG_SYNC,
    VTG_BACK
  } vtg_region_t;

  // Classify a counter value against its layout
  function automatic vtg_region_t vtg_region(input vtg_count_t cnt, input vtg_count_t vis,
                                             input vtg_count_t fp, input vtg_count_t sw);
    if (cnt < vis) return VTG_VISIBLE;
    else if (cnt < vis + fp) return VTG_FRONT;
    else if (cnt < vis + fp + sw) return VTG_SYNC;
    else return VTG_BACK;
  endfunction : vtg_region

  // Increment that wraps to zero after the last value
  function automatic vtg_count_t vtg_wrap_inc(input vtg_count_t cnt, input vtg_count_t last);
    return (cnt == last) ? '0 : cnt + vtg_count_t'(1);
  endfunction : vtg_wrap_inc

endpackage : vtg_pkg

// >>> logic/vtg_stream_if.sv
// Valid/ready word stream between the generator and its pixel buffer
`timescale 1ns/1ps
interface vtg_stream_if #(
  parameter int WIDTH = 12
);
  logic             valid;  // Word on data is offered
  logic             ready;  // Receiver takes the word
  logic [WIDTH-1:0] data;   // Word itself

  // Producing side
  modport src (output valid, output data, input ready);
  // Consuming side
  modport snk (input valid, input data, output ready);
endinterface : vtg_stream_if

// >>> logic/vtg_pix_buf.sv
// Two-entry pixel buffer with valid/ready on both sides
`timescale 1ns/1ps
// Width and depth defaults
`include "vtg_map.svh"
module vtg_pix_buf
  import vtg_pkg::*;
#(
  parameter int WIDTH = `VTG_PIX_W,
  parameter int DEPTH = `VTG_BUF_DEPTH
) (
  input  logic   sys_clk,
  input  logic   srst,
  input  logic   clk_en,
  vtg_stream_if.snk in_if,
  vtg_stream_if.src out_if
);

  localparam int IDX_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CNT_W = $clog2(DEPTH + 1);
  localparam logic [IDX_W-1:0] IDX_LAST = IDX_W'(DEPTH - 1);
  localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];  // Entry storage
  logic [WIDTH-1:0] mem_d [DEPTH];  // Next entry storage
  logic [IDX_W-1:0] wr_idx_q;       // Next entry to fill
  logic [IDX_W-1:0] wr_idx_d;
  logic [IDX_W-1:0] rd_idx_q;       // Oldest entry
  logic [IDX_W-1:0] rd_idx_d;
  logic [CNT_W-1:0] fill_q;         // Entries held
  logic [CNT_W-1:0] fill_d;
  logic             push;           // Word taken this cycle
  logic             pop;            // Word leaves this cycle

  ////////////////////////////////////////////////////////////////////////
  // Handshakes: no room means no ready, frozen means no transfer
  assign in_if.ready  = clk_en && (fill_q != CNT_FULL);
  assign out_if.valid = clk_en && (fill_q != '0);
  assign out_if.data  = mem_q[rd_idx_q];
  assign push         = in_if.valid && in_if.ready;
  assign pop          = out_if.valid && out_if.ready;

  ////////////////////////////////////////////////////////////////////////
  // Next pointers, fill level and storage
  always_comb begin
    mem_d    = mem_q;
    wr_idx_d = wr_idx_q;
    rd_idx_d = rd_idx_q;
    fill_d   = fill_q;
    // Store incoming word
    if (push) begin
      mem_d[wr_idx_q] = in_if.data;
      wr_idx_d        = (wr_idx_q == IDX_LAST) ? '0 : wr_idx_q + IDX_W'(1);
    end
    // Release oldest word
    if (pop) begin
      rd_idx_d = (rd_idx_q == IDX_LAST) ? '0 : rd_idx_q + IDX_W'(1);
    end
    // Level follows both moves
    if (push && !pop) begin
      fill_d = fill_q + CNT_W'(1);
    end else if (pop && !push) begin
      fill_d = fill_q - CNT_W'(1);
    end
  end

  // Register state; reset empties the buffer
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      wr_idx_q <= '0;
      rd_idx_q <= '0;
      fill_q   <= '0;
    end else begin
      wr_idx_q <= wr_idx_d;
      rd_idx_q <= rd_idx_d;
      fill_q   <= fill_d;
    end
    mem_q <= mem_d;
  end

endmodule : vtg_pix_buf

// >>> logic/vtg_timing_top.sv
// 640x480 video timing generator with pixel fetch and color output
`timescale 1ns/1ps
// Layout constants, shared with the package
`include "vtg_map.svh"
module vtg_timing_top
  import vtg_pkg::*;
#(
  parameter int PIX_DIV = `VTG_PIX_DIV
) (
  input  logic                   sys_clk,
  input  logic                   srst,
  input  logic                   clk_en,
  output logic                   mem_req_valid,
  input  logic                   mem_req_ready,
  output logic [`VTG_ADDR_W-1:0] mem_req_addr,
  input  logic                   mem_rd_valid,
  output logic                   mem_rd_ready,
  input  logic [`VTG_PIX_W-1:0]  mem_rd_data,
  output logic [`VTG_CHAN_W-1:0] vga_red,
  output logic [`VTG_CHAN_W-1:0] vga_green,
  output logic [`VTG_CHAN_W-1:0] vga_blue,
  output logic                   horizontal_sync_out,
  output logic                   vertical_sync_out,
  output logic [`VTG_CNT_W-1:0]  scan_col,
  output logic [`VTG_CNT_W-1:0]  scan_row,
  output logic                   underrun_pulse
);

  ////////////////////////////////////////////////////////////////////////
  // Constants

  // Divider width and terminal count
  localparam int               DIV_W    = (PIX_DIV > 1) ? $clog2(PIX_DIV) : 1;
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(PIX_DIV - 1);

  // Last column and last row of the raster
  // Back porch closes each total
  // Whatever follows sync up to the last count is back porch
  localparam vtg_count_t H_LAST = vtg_count_t'(`VTG_H_TOTAL - 1);
  localparam vtg_count_t V_LAST = vtg_count_t'(`VTG_V_TOTAL - 1);

  // Layout thresholds at counter width
  // Visible, porch and sync sums stay below 1024
  localparam vtg_count_t H_VIS = vtg_count_t'(`VTG_H_VISIBLE);
  localparam vtg_count_t H_FP  = vtg_count_t'(`VTG_H_FRONT);
  localparam vtg_count_t H_SW  = vtg_count_t'(`VTG_H_SYNC);
  localparam vtg_count_t V_VIS = vtg_count_t'(`VTG_V_VISIBLE);
  // Vertical front porch in lines
  localparam vtg_count_t V_FP  = vtg_count_t'(`VTG_V_FRONT);
  localparam vtg_count_t V_SW  = vtg_count_t'(`VTG_V_SYNC);

  ////////////////////////////////////////////////////////////////////////
  // Declarations

  // Each register pairs with a next-value signal
  // Only the always_ff blocks write the _q side
  logic [DIV_W-1:0] div_q;       // Position within one pixel period
  logic [DIV_W-1:0] div_d;
  logic             pix_tick;    // Last system clock of a pixel period
  vtg_count_t       h_q;         // Column counter
  vtg_count_t       h_d;
  vtg_count_t       v_q;         // Row counter
  vtg_count_t       v_d;
  vtg_count_t       h_nxt;       // Column after this pixel
  vtg_count_t       v_nxt;       // Row after this pixel
  vtg_region_t      h_reg;       // Where the column lies in the line
  vtg_region_t      v_reg;       // Where the row lies in the frame
  logic             cur_vis;     // Current pixel lies in the picture
  logic             nxt_vis;     // Next pixel lies in the picture
  vtg_pixel_t       color_q;     // Color shown on the pins
  vtg_pixel_t       color_d;
  logic             hs_n_q;      // Registered horizontal sync, low active
  logic             hs_n_d;
  logic             vs_n_q;      // Registered vertical sync, low active
  logic             vs_n_d;
  logic             under_q;     // Missing pixel flag, one clock
  logic             under_d;
  logic             req_valid_q; // Fetch request pending
  logic             req_valid_d;
  vtg_addr_t        req_addr_q;  // Address of pending fetch
  vtg_addr_t        req_addr_d;

  // Buffer ports on both sides
  vtg_stream_if #(.WIDTH(`VTG_PIX_W)) fill_if ();
  vtg_stream_if #(.WIDTH(`VTG_PIX_W)) drain_if ();

  ////////////////////////////////////////////////////////////////////////
  // Pixel rate

  // Divider counts system clocks within one pixel
  // Tick marks the last of them; all pixel state moves there
  // Pixel tick divider
  assign pix_tick = clk_en && (div_q == DIV_LAST);

  ////////////////////////////////////////////////////////////////////////
  // Raster counters

  // Origin at the first visible pixel keeps decode simple
  // Both counters hold while clock enable is low
  // Row wraps after the last line of the frame
  // Column steps each pixel
  assign h_nxt = vtg_wrap_inc(h_q, H_LAST);

  assign v_nxt = (h_q == H_LAST) ? vtg_wrap_inc(v_q, V_LAST) : v_q;

  // Next divider and counter values
  always_comb begin
    div_d = div_q;
    h_d   = h_q;
    v_d   = v_q;
    // Frozen while clock enable is low
    if (clk_en) begin
      div_d = (div_q == DIV_LAST) ? '0 : div_q + DIV_W'(1);
    end
    if (pix_tick) begin
      h_d = h_nxt;
      v_d = v_nxt;
    end
  end

  // Register divider and counters
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      div_q <= '0;
      h_q   <= '0;
      v_q   <= '0;
    end else begin
      div_q <= div_d;
      h_q   <= h_d;
      v_q   <= v_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Region decode

  // Decode reads the counters before they step,
  // so pins trail the counters by one pixel period
  // Origin at first visible pixel
  assign h_reg = vtg_region(h_q, H_VIS, H_FP, H_SW);
  assign v_reg = vtg_region(v_q, V_VIS, V_FP, V_SW);

  assign cur_vis = (h_reg == VTG_VISIBLE) && (v_reg == VTG_VISIBLE);
  assign nxt_vis = (h_nxt < H_VIS) && (v_nxt < V_VIS);

  ////////////////////////////////////////////////////////////////////////
  // Fetch requests

  // Request leaves one pixel period ahead of its display tick
  // Memory then has four system clocks to answer before the pop
  // A request still unaccepted at the next tick is replaced
  // Dropped requests surface later as an underrun pulse
  // Next request state
  always_comb begin
    req_valid_d = req_valid_q;
    req_addr_d  = req_addr_q;
    // Accepted request retires
    if (clk_en && mem_req_ready) begin
      req_valid_d = 1'b0;
    end
    // Fetch next pixel one period early
    if (pix_tick) begin
      req_valid_d = nxt_vis;
      // Row and column form the address
      req_addr_d  = {v_nxt[`VTG_ADDR_ROW_W-1:0], h_nxt};
    end
  end

  // Register request; reset asks for pixel zero at once
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      req_valid_q <= 1'b1;
      req_addr_q  <= '0;
    end else begin
      req_valid_q <= req_valid_d;
      req_addr_q  <= req_addr_d;
    end
  end

  // Request stands until taken or replaced
  // Offer request only while running
  assign mem_req_valid = req_valid_q && clk_en;
  assign mem_req_addr  = req_addr_q;

  ////////////////////////////////////////////////////////////////////////
  // Return path buffer

  // Buffer absorbs memory latency between ticks
  // A full buffer holds back the memory side
  // Words leave strictly in fetch order
  // Memory words enter the buffer
  assign fill_if.valid = mem_rd_valid;
  assign fill_if.data  = mem_rd_data;
  // Buffer back-pressure reaches memory
  assign mem_rd_ready  = fill_if.ready;

  // Pop only at visible pixel ticks
  assign drain_if.ready = pix_tick && cur_vis;

  // Depth two covers one word in flight and one waiting
  // Two-entry buffer between memory and pins
  vtg_pix_buf #(
    .WIDTH (`VTG_PIX_W),
    .DEPTH (`VTG_BUF_DEPTH)
  ) u_pix_buf (
    .sys_clk (sys_clk),
    .srst    (srst),
    .clk_en  (clk_en),
    .in_if   (fill_if),
    .out_if  (drain_if)
  );

  ////////////////////////////////////////////////////////////////////////
  // Output stage

  // Color and sync pins change only the edge after a pixel tick
  // Color and sync values then stand for a whole pixel period; the underrun pulse lasts one clock
  // An empty buffer at a visible tick shows black
  // Next color, sync and underrun values
  always_comb begin
    color_d = color_q;
    hs_n_d  = hs_n_q;
    vs_n_d  = vs_n_q;
    under_d = 1'b0;
    if (pix_tick) begin
      hs_n_d = (h_reg != VTG_SYNC);
      vs_n_d = (v_reg != VTG_SYNC);
      if (cur_vis) begin
        color_d = drain_if.valid ? drain_if.data : `VTG_BLANK;
        under_d = !drain_if.valid;
      end else begin
        color_d = `VTG_BLANK;
      end
    end
  end

  // Register pin values
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      color_q <= `VTG_BLANK;
      hs_n_q  <= `VTG_SYNC_IDLE;
      vs_n_q  <= `VTG_SYNC_IDLE;
      under_q <= 1'b0;
    end else begin
      color_q <= color_d;
      hs_n_q  <= hs_n_d;
      vs_n_q  <= vs_n_d;
      under_q <= under_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pins

  assign vga_red   = color_q[`VTG_RED_LSB +: `VTG_CHAN_W];
  assign vga_green = color_q[`VTG_GREEN_LSB +: `VTG_CHAN_W];
  assign vga_blue  = color_q[`VTG_BLUE_LSB +: `VTG_CHAN_W];

  // No logic after the flops keeps edges clean
  // Sync pins straight from flops
  assign horizontal_sync_out = hs_n_q;
  assign vertical_sync_out   = vs_n_q;

  // Status outputs for observers and test
  // Scan position for observers
  assign scan_col = h_q;
  assign scan_row = v_q;

  // Pulse means a pixel was shown black
  // Fetch arrived too late
  assign underrun_pulse = under_q;

endmodule : vtg_timing_top

// >>> bench/vtg_timing_sva.sv
// Port checker for the video timing generator
`timescale 1ns/1ps
module vtg_timing_sva #(
  parameter int PIX_DIV = 5
) (
  input wire logic        sys_clk,
  input wire logic        srst,
  input wire logic        clk_en,
  input wire logic        mem_req_valid,
  input wire logic [18:0] mem_req_addr,
  input wire logic        mem_rd_ready,
  input wire logic [3:0]  vga_red,
  input wire logic [3:0]  vga_green,
  input wire logic [3:0]  vga_blue,
  input wire logic        horizontal_sync_out,
  input wire logic        vertical_sync_out,
  input wire logic [9:0]  scan_col,
  input wire logic [9:0]  scan_row,
  input wire logic        underrun_pulse
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  logic [11:0] pix_w;  // Colors as one word
  assign pix_w = {vga_red, vga_green, vga_blue};
  ////////////////////////////////////////////////////////////
  // Column step and the four quiet cycles after it
  sequence s_col_step; $changed(scan_col); endsequence
  sequence s_hold; $stable(scan_col) [*4]; endsequence
  property p_pix_hold; s_col_step |=> s_hold; endproperty
  a_pix_hold: assert property (p_pix_hold) else $error("column moved early");
  property p_col_next;
    s_col_step |-> scan_col == (($past(scan_col) == 10'h31F) ? 10'h000 : $past(scan_col) + 10'h001);
  endproperty
  a_col_next: assert property (p_col_next) else $error("column step wrong");
  property p_row_next;
    $changed(scan_row) |-> $past(scan_col) == 10'h31F && scan_col == 10'h000 &&
      scan_row == (($past(scan_row) == 10'h208) ? 10'h000 : $past(scan_row) + 10'h001);
  endproperty
  a_row_next: assert property (p_row_next) else $error("row step wrong");
  property p_range; scan_col <= 10'h31F && scan_row <= 10'h208; endproperty
  a_range: assert property (p_range) else $error("counter out of range");
  property p_hs_fall; $fell(horizontal_sync_out) |-> scan_col == 10'h291; endproperty
  a_hs_fall: assert property (p_hs_fall) else $error("hsync starts off place");
  property p_hs_rise; $rose(horizontal_sync_out) |-> scan_col == 10'h2F1; endproperty
  a_hs_rise: assert property (p_hs_rise) else $error("hsync ends off place");
  property p_vs_high; scan_row inside {[10'h001:10'h1E9]} |-> vertical_sync_out; endproperty
  a_vs_high: assert property (p_vs_high) else $error("vsync low too early");
  property p_vs_low; !vertical_sync_out |-> scan_row inside {10'h1EA, 10'h1EB, 10'h1EC}; endproperty
  a_vs_low: assert property (p_vs_low) else $error("vsync low off rows");
  property p_blank; pix_w != 12'h000 |-> scan_col inside {[10'h001:10'h280]} && scan_row < 10'h1E0; endproperty
  a_blank: assert property (p_blank) else $error("color outside visible area");
  property p_underrun; underrun_pulse |-> pix_w == 12'h000 ##1 !underrun_pulse; endproperty
  a_underrun: assert property (p_underrun) else $error("underrun not black or long");
  property p_freeze; !clk_en |-> !mem_req_valid && !mem_rd_ready ##1 $stable(scan_col); endproperty
  a_freeze: assert property (p_freeze) else $error("moved while disabled");
  property p_req_addr; mem_req_valid |-> mem_req_addr[9:0] < 10'h280 && mem_req_addr[18:10] < 9'h1E0; endproperty
  a_req_addr: assert property (p_req_addr) else $error("fetch outside visible area");
endmodule : vtg_timing_sva
bind vtg_timing_top vtg_timing_sva #(.PIX_DIV(PIX_DIV)) u_sva (.sys_clk, .srst, .clk_en, .mem_req_valid,
  .mem_req_addr, .mem_rd_ready, .vga_red, .vga_green, .vga_blue, .horizontal_sync_out,
  .vertical_sync_out, .scan_col, .scan_row, .underrun_pulse);

// >>> bench/vtg_mem_model.sv
// Refresh memory model answering pixel fetches
`timescale 1ns/1ps
module vtg_mem_model (
  input  wire logic        sys_clk,
  input  wire logic        srst,
  input  wire logic        mem_req_valid,
  output      logic        mem_req_ready,
  input  wire logic [18:0] mem_req_addr,
  output      logic        mem_rd_valid,
  input  wire logic        mem_rd_ready,
  output      logic [11:0] mem_rd_data,
  input  wire logic        slow,
  input  wire logic        stall
);
  logic        pend_q;  // Fetch taken, word not out yet
  logic        wait_q;  // Extra latency cycle left
  logic [11:0] word_q;  // Fetched word
  // Stall refuses fetches
  assign mem_req_ready = !stall && !srst;
  // Fetch, delay, then offer word; released data is inverted
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      pend_q       <= 1'b0;
      mem_rd_valid <= 1'b0;
      mem_rd_data  <= 12'hFFF;
    end else begin
      if (mem_rd_valid && mem_rd_ready) begin
        mem_rd_valid <= 1'b0;
        mem_rd_data  <= ~mem_rd_data;
      end
      if (mem_req_valid && mem_req_ready) begin
        pend_q <= 1'b1;
        wait_q <= slow;
        word_q <= {mem_req_addr[13:10], mem_req_addr[7:0]};
      end else if (pend_q && wait_q) begin
        wait_q <= 1'b0;
      end else if (pend_q) begin
        pend_q       <= 1'b0;
        mem_rd_valid <= 1'b1;
        mem_rd_data  <= word_q;
      end
    end
  end
endmodule : vtg_mem_model

// >>> bench/vtg_timing_top_tb_top.sv
// Testbench for the video timing generator
`timescale 1ns/1ps
module vtg_timing_top_tb_top;
  logic        sys_clk, srst, clk_en, slow, stall;
  logic        mem_req_valid, mem_req_ready, mem_rd_valid, mem_rd_ready;
  logic [18:0] mem_req_addr;
  logic [11:0] mem_rd_data, pix;
  logic [3:0]  vga_red, vga_green, vga_blue;
  logic        horizontal_sync_out, vertical_sync_out, underrun_pulse;
  logic [9:0]  scan_col, scan_row;
  int          err_total, check_count;
  assign pix = {vga_red, vga_green, vga_blue};
  vtg_timing_top #(.PIX_DIV(5)) dut (.sys_clk, .srst, .clk_en, .mem_req_valid, .mem_req_ready,
    .mem_req_addr, .mem_rd_valid, .mem_rd_ready, .mem_rd_data, .vga_red, .vga_green, .vga_blue,
    .horizontal_sync_out, .vertical_sync_out, .scan_col, .scan_row, .underrun_pulse);
  vtg_mem_model u_mem (.sys_clk, .srst, .mem_req_valid, .mem_req_ready, .mem_req_addr,
    .mem_rd_valid, .mem_rd_ready, .mem_rd_data, .slow, .stall);
  // 125 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  ////////////////////////////////////////////////////////////
  task automatic close_out;
    $display("errors %0d checks %0d", err_total, check_count);
    if (err_total == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : close_out
  task automatic check(input logic [31:0] seen, input logic [31:0] expd, input string what);
    check_count++;
    if (seen !== expd) begin
      err_total++;
      $display("unexpected at %0t: %s seen %0h expected %0h", $time, what, seen, expd);
    end
  endtask : check
  // Which: 0 column, 1 hsync, 2 underrun
  function automatic logic hit(input int which, input logic [9:0] v);
    if (which == 0) return scan_col === v;
    if (which == 1) return horizontal_sync_out === v[0];
    return underrun_pulse === v[0];
  endfunction : hit
  // Bounded wait at falling edges, returns cycles spent
  task automatic wait_for(input int which, input logic [9:0] v, output int n);
    n = 0;
    while (!hit(which, v)) begin
      @(negedge sys_clk);
      n++;
      if (n > 5000) begin
        err_total++;
        close_out;
      end
    end
  endtask : wait_for
  // Pixel word shown for a column of the current row
  function automatic logic [11:0] exp_pix(input logic [9:0] r, input logic [9:0] c);
    return (c < 10'h280 && r < 10'h1E0) ? {r[3:0], c[7:0]} : 12'h000;
  endfunction : exp_pix
  ////////////////////////////////////////////////////////////
  task automatic t_reset;
    int n;
    check(pix, 12'h000, "reset color");
    check({horizontal_sync_out, vertical_sync_out}, 2'b11, "reset sync");
    check({scan_col, scan_row}, 20'h00000, "reset count");
    srst = 1'b0;
    n = 0;
    do begin
      @(negedge sys_clk);
      n++;
    end while (scan_col === 10'h000 && n < 20);
    check(n, 5, "first tick");
  endtask : t_reset
  task automatic t_line;
    int n;
    logic [9:0] r0;
    wait_for(0, 10'h000, n);
    wait_for(1, 10'h000, n);
    check(scan_col, 10'h291, "hsync start");
    wait_for(1, 10'h001, n);
    check(n, 480, "hsync width");
    check(scan_col, 10'h2F1, "hsync end");
    r0 = scan_row;
    wait_for(0, 10'h000, n);
    check(scan_row, r0 + 10'h001, "row step");
    wait_for(0, 10'h001, n);
    wait_for(0, 10'h000, n);
    check(n, 3995, "line length");
    check(vertical_sync_out, 1'b1, "vsync idle");
  endtask : t_line
  task automatic t_pixels;
    int n;
    logic [9:0] cols [8] = '{10'h002, 10'h003, 10'h064, 10'h27F, 10'h280, 10'h281, 10'h282, 10'h2BC};
    foreach (cols[i]) begin
      wait_for(0, cols[i], n);
      check(pix, exp_pix(scan_row, cols[i] - 10'h001), "pixel");
    end
  endtask : t_pixels
  task automatic t_slow;
    slow = 1'b1;
    t_pixels;
    slow = 1'b0;
  endtask : t_slow
  task automatic t_underrun;
    int n;
    wait_for(0, 10'h064, n);
    stall = 1'b1;
    wait_for(2, 10'h001, n);
    check(n <= 10, 1'b1, "underrun seen");
    check(pix, 12'h000, "underrun black");
    stall = 1'b0;
    wait_for(0, 10'h06E, n);
    check(pix, exp_pix(scan_row, 10'h06D), "recovered");
  endtask : t_underrun
  task automatic t_freeze;
    int n;
    logic [9:0] c0;
    wait_for(0, 10'h0C8, n);
    clk_en = 1'b0;
    c0 = scan_col;
    repeat (20) @(negedge sys_clk);
    check(scan_col, c0, "frozen");
    check(mem_req_valid, 1'b0, "no fetch");
    clk_en = 1'b1;
    wait_for(0, c0 + 10'h002, n);
    check(pix, exp_pix(scan_row, c0 + 10'h001), "resumed");
  endtask : t_freeze
  task automatic t_rereset;
    srst = 1'b1;
    repeat (3) @(negedge sys_clk);
    t_reset;
    t_pixels;
  endtask : t_rereset
  ////////////////////////////////////////////////////////////
  initial begin
    srst = 1'b1;
    clk_en = 1'b1;
    slow = 1'b0;
    stall = 1'b0;
    err_total = 0;
    check_count = 0;
    repeat (8) @(negedge sys_clk);
    t_reset;
    t_pixels;
    t_line;
    t_slow;
    t_underrun;
    t_freeze;
    t_rereset;
    close_out;
  end
  // Hang guard
  initial begin
    #780000;
    err_total++;
    close_out;
  end
endmodule : vtg_timing_top_tb_top
